// [common/pthru_pkg.sv]
/*
 * constants and carrier types of the sram pass-through handshake block.
 * assumes one core clock of 25 mhz; the contactless link is sampled on it.
 */
// How it works
// - reader writes ffh: host ready, hand to i2c
// - field-detect pulse when data ready for host
// - i2c address match sets i2c lock
// - host reads ffh: clear host ready, lock
// - host writes fbh: reader ready, unlock i2c
// - after handover reader lock set automatically
// - reader read covering ffh clears ready, lock
// - field-detect pulse when reader consumed data
package pthru_pkg;

    // ****************************************************************
    // page addresses of the sram window
    // ****************************************************************
    localparam logic [7:0] RF_TERM_PAGE  = 8'h00FF; // reader terminator
    localparam logic [7:0] I2C_TERM_PAGE = 8'h00FB; // host terminator block

    // ****************************************************************
    // configuration field: event on/off select, code for pass-through
    // ****************************************************************
    localparam int         SEL_ON_LSB  = 2;         // bits 3:2
    localparam int         SEL_OFF_LSB = 4;         // bits 5:4
    localparam logic [1:0] SEL_PTHRU   = 2'h3;      // pass-through code

    // ****************************************************************
    // reset values and timing
    // ****************************************************************
    localparam logic       FLAG_RESET     = 1'b0;
    localparam int         CLK_PERIOD_NS  = 40;
    localparam int         FD_PULSE_NS    = 1000;   // field-detect low time
    localparam int         FD_PULSE_CYC   =
        (FD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] FD_PULSE_LAST  = 6'(FD_PULSE_CYC - 1);

    // contactless side samples, carried through the synchroniser together
    typedef struct packed {
        logic       clk;        // link clock level
        logic       req;        // reader wants the buffer
        logic       wr_done;    // write command finished
        logic       rd_done;    // read / burst read finished
        logic [7:0] first_page; // first page touched
        logic [7:0] last_page;  // last page touched
    } rf_sample_t;

    // ownership of the buffer
    typedef enum logic [1:0] {
        ARB_IDLE,
        ARB_RF,
        ARB_I2C
    } arb_state_t;

endpackage

// [src/sram_passthrough_handshake.sv]
/*
 * arbitration and ready/lock handshake for the 64-byte pass-through sram.
 * assumes: contactless command results arrive as levels that stay stable
 * over a rising edge of I_RF_CLK; i2c slave results are one-cycle pulses
 * on the core clock; the field-detect pin has an external pull-up.
 */
`timescale 1ns/1ps

module sram_passthrough_handshake (
    // clock and reset
    input  wire logic       I_CORE_CLK,
    input  wire logic       I_RESETN,
    // contactless link, asynchronous to the core clock
    input  wire logic       I_RF_CLK,
    input  wire logic       I_RF_REQ,
    input  wire logic       I_RF_WR_DONE,
    input  wire logic       I_RF_RD_DONE,
    input  wire logic [7:0] I_RF_FIRST_PAGE,
    input  wire logic [7:0] I_RF_LAST_PAGE,
    // i2c slave results, core clock domain
    input  wire logic       I_I2C_ADDR_MATCH,
    input  wire logic       I_I2C_WR_DONE,
    input  wire logic       I_I2C_RD_DONE,
    input  wire logic [7:0] I_I2C_PAGE,
    // configuration bits 5:2
    input  wire logic [1:0] I_EVENT_ON_SELECT,
    input  wire logic [1:0] I_EVENT_OFF_SELECT,
    // session status
    output logic            O_HOST_READY,
    output logic            O_READER_DATA_READY,
    output logic            O_READER_LOCK,
    output logic            O_I2C_LOCK,
    // field-detect open-drain pin
    output logic            O_FIELD_DETECT_PIN_OUT,
    output logic            O_FIELD_DETECT_PIN_OE
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // a burst from first to last page covers the terminator page
    function automatic logic covers_term(input logic [7:0] first,
                                         input logic [7:0] last);
        covers_term = (first <= pthru_pkg::RF_TERM_PAGE) &&
                      (last  >= pthru_pkg::RF_TERM_PAGE);
    endfunction

    // ****************************************************************
    // link synchroniser
    // ****************************************************************
    pthru_pkg::rf_sample_t rf_meta;   // first stage, read by rf_sync only
    pthru_pkg::rf_sample_t rf_sync;   // second stage, safe to use
    logic                  rf_clk_d;  // previous synced link clock
    pthru_pkg::rf_sample_t next_rf_meta;
    pthru_pkg::rf_sample_t next_rf_sync;
    logic                  next_rf_clk_d;
    logic                  rf_edge;   // rising link clock edge seen

    // gather pins into one carrier for the two-stage crossing
    always_comb begin
        next_rf_meta = '{clk: I_RF_CLK, req: I_RF_REQ,
                         wr_done: I_RF_WR_DONE, rd_done: I_RF_RD_DONE,
                         first_page: I_RF_FIRST_PAGE,
                         last_page: I_RF_LAST_PAGE};
        next_rf_sync  = rf_meta;
        next_rf_clk_d = rf_sync.clk;
    end

    // register the synchroniser stages
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            rf_meta  <= '0;
            rf_sync  <= '0;
            rf_clk_d <= 1'b0;
        end else begin
            rf_meta  <= next_rf_meta;
            rf_sync  <= next_rf_sync;
            rf_clk_d <= next_rf_clk_d;
        end
    end

    // data is taken from the same sample that first shows the link clock
    // high, so it must already be stable over the link edge to be trusted
    assign rf_edge = rf_sync.clk && !rf_clk_d;

    // ****************************************************************
    // arbitration and flags
    // ****************************************************************
    pthru_pkg::arb_state_t state;
    pthru_pkg::arb_state_t next_state;
    logic                  host_ready;
    logic                  reader_ready;
    logic                  next_host_ready;
    logic                  next_reader_ready;
    logic                  ev_host;       // data now waits for the host
    logic                  ev_consumed;   // reader has taken its data
    logic                  rf_wr_term;
    logic                  rf_rd_term;
    logic                  i2c_wr_term;
    logic                  i2c_rd_term;

    // terminator accesses, each gated by ownership of its side
    always_comb begin
        rf_wr_term  = (state == pthru_pkg::ARB_RF) && rf_edge &&
                      rf_sync.wr_done &&
                      (rf_sync.last_page == pthru_pkg::RF_TERM_PAGE);
        rf_rd_term  = (state == pthru_pkg::ARB_RF) && rf_edge &&
                      rf_sync.rd_done &&
                      covers_term(rf_sync.first_page,
                                  rf_sync.last_page);
        i2c_wr_term = (state == pthru_pkg::ARB_I2C) && I_I2C_WR_DONE &&
                      (I_I2C_PAGE == pthru_pkg::I2C_TERM_PAGE);
        i2c_rd_term = (state == pthru_pkg::ARB_I2C) && I_I2C_RD_DONE &&
                      (I_I2C_PAGE == pthru_pkg::RF_TERM_PAGE);
    end

    // next ownership and ready flags
    always_comb begin
        next_state        = state;
        next_host_ready   = host_ready;
        next_reader_ready = reader_ready;
        ev_host           = 1'b0;
        ev_consumed       = 1'b0;
        case (state)
            pthru_pkg::ARB_IDLE: begin
                if (reader_ready) begin
                    // data for the reader: it takes the lock at once
                    next_state = pthru_pkg::ARB_RF;
                end else if (I_I2C_ADDR_MATCH) begin
                    next_state = pthru_pkg::ARB_I2C;
                end else if (rf_edge && rf_sync.req && !host_ready) begin
                    // reader may not overwrite data the host has not read
                    next_state = pthru_pkg::ARB_RF;
                end
            end
            pthru_pkg::ARB_RF: begin
                if (rf_wr_term) begin
                    next_host_ready = 1'b1;
                    ev_host         = 1'b1;
                    next_state      = pthru_pkg::ARB_IDLE;
                end else if (rf_rd_term) begin
                    next_reader_ready = 1'b0;
                    ev_consumed       = 1'b1;
                    next_state        = pthru_pkg::ARB_IDLE;
                end else if (rf_edge && !rf_sync.req && !reader_ready) begin
                    // reader left without handing over: free the buffer
                    next_state = pthru_pkg::ARB_IDLE;
                end
            end
            pthru_pkg::ARB_I2C: begin
                if (i2c_wr_term) begin
                    next_reader_ready = 1'b1;
                    next_state        = pthru_pkg::ARB_IDLE;
                end else if (i2c_rd_term) begin
                    next_host_ready = 1'b0;
                    next_state      = pthru_pkg::ARB_IDLE;
                end
            end
            default: begin
                next_state = pthru_pkg::ARB_IDLE;
            end
        endcase
    end

    // register ownership and flags
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            state        <= pthru_pkg::ARB_IDLE;
            host_ready   <= pthru_pkg::FLAG_RESET;
            reader_ready <= pthru_pkg::FLAG_RESET;
        end else begin
            state        <= next_state;
            host_ready   <= next_host_ready;
            reader_ready <= next_reader_ready;
        end
    end

    // ****************************************************************
    // status outputs, registered from the next values
    // ****************************************************************
    logic next_reader_lock;
    logic next_i2c_lock;

    // locks mirror ownership; flags are what either side polls
    always_comb begin
        next_reader_lock = (next_state == pthru_pkg::ARB_RF);
        next_i2c_lock    = (next_state == pthru_pkg::ARB_I2C);
    end

    // register status so each output leaves a flop
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            O_HOST_READY        <= pthru_pkg::FLAG_RESET;
            O_READER_DATA_READY <= pthru_pkg::FLAG_RESET;
            O_READER_LOCK       <= pthru_pkg::FLAG_RESET;
            O_I2C_LOCK          <= pthru_pkg::FLAG_RESET;
        end else begin
            O_HOST_READY        <= next_host_ready;
            O_READER_DATA_READY <= next_reader_ready;
            O_READER_LOCK       <= next_reader_lock;
            O_I2C_LOCK          <= next_i2c_lock;
        end
    end

    // ****************************************************************
    // field-detect pulse
    // ****************************************************************
    logic [5:0] fd_count;     // cycles left in the low pulse
    logic       fd_active;
    logic [5:0] next_fd_count;
    logic       next_fd_active;
    logic       fd_fire;

    // pick the enabled event; a new event restarts a running pulse
    always_comb begin
        fd_fire = (ev_host &&
                   I_EVENT_ON_SELECT == pthru_pkg::SEL_PTHRU) ||
                  (ev_consumed &&
                   I_EVENT_OFF_SELECT == pthru_pkg::SEL_PTHRU);
        next_fd_count  = fd_count;
        next_fd_active = fd_active;
        if (fd_fire) begin
            next_fd_active = 1'b1;
            next_fd_count  = pthru_pkg::FD_PULSE_LAST;
        end else if (fd_active) begin
            if (fd_count == 6'h0000) begin
                next_fd_active = 1'b0;
            end else begin
                next_fd_count = fd_count - 6'h0001;
            end
        end
    end

    // register the pulse; the pin is only ever pulled low
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            fd_count               <= 6'h0000;
            fd_active              <= 1'b0;
            O_FIELD_DETECT_PIN_OUT <= 1'b0;
            O_FIELD_DETECT_PIN_OE  <= 1'b1;
        end else begin
            fd_count               <= next_fd_count;
            fd_active              <= next_fd_active;
            O_FIELD_DETECT_PIN_OUT <= 1'b0;
            O_FIELD_DETECT_PIN_OE  <= !next_fd_active;
        end
    end

endmodule

// [test/pthru_monitor.sv]
/* port checker of the pass-through handshake block.
   assumes it is bound onto the top module at the foot of this file. */
`timescale 1ns/1ps
module pthru_monitor (
    // clock, reset, i2c results and select bits
    input wire logic       I_CORE_CLK,
    input wire logic       I_RESETN,
    input wire logic       I_I2C_ADDR_MATCH,
    input wire logic       I_I2C_WR_DONE,
    input wire logic       I_I2C_RD_DONE,
    input wire logic [7:0] I_I2C_PAGE,
    input wire logic [1:0] I_EVENT_ON_SELECT,
    input wire logic [1:0] I_EVENT_OFF_SELECT,
    // status flags and the field-detect pin
    input wire logic       O_HOST_READY,
    input wire logic       O_READER_DATA_READY,
    input wire logic       O_READER_LOCK,
    input wire logic       O_I2C_LOCK,
    input wire logic       O_FIELD_DETECT_PIN_OUT,
    input wire logic       O_FIELD_DETECT_PIN_OE
);
    logic [5:0] low_cnt; // cycles the pin has been pulled low
    // a counter, because a 25-cycle repetition would be too long to unroll
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN || O_FIELD_DETECT_PIN_OE) begin
            low_cnt <= 6'h00;
        end else begin
            low_cnt <= low_cnt + 6'h01;
        end
    end
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESETN);
    reader_hand_a: assert property (
        $rose(O_HOST_READY) |-> $past(O_READER_LOCK) && !O_READER_LOCK)
        else $error("host ready set without reader handover");
    on_pulse_a: assert property (
        $rose(O_HOST_READY) && I_EVENT_ON_SELECT == 2'h3
        |-> ##[0:1] !O_FIELD_DETECT_PIN_OE) else $error("no ready pulse");
    pin_low_a: assert property (
        !O_FIELD_DETECT_PIN_OE |-> !O_FIELD_DETECT_PIN_OUT)
        else $error("pin driven high");
    pulse_width_a: assert property (
        $rose(O_FIELD_DETECT_PIN_OE) |-> low_cnt == 6'h19)
        else $error("pin pulse width off");
    addr_lock_a: assert property (
        I_I2C_ADDR_MATCH && !O_I2C_LOCK && !O_READER_LOCK
        && !O_READER_DATA_READY |=> O_I2C_LOCK)
        else $error("address match did not lock");
    host_read_a: assert property (
        O_I2C_LOCK && I_I2C_RD_DONE && I_I2C_PAGE == 8'hFF
        |=> !O_HOST_READY && !O_I2C_LOCK) else $error("read not freed");
    host_write_a: assert property (
        O_I2C_LOCK && I_I2C_WR_DONE && I_I2C_PAGE == 8'hFB
        |=> O_READER_DATA_READY && !O_I2C_LOCK)
        else $error("write not handed over");
    auto_grant_a: assert property (
        $rose(O_READER_DATA_READY) |=> O_READER_LOCK)
        else $error("reader not granted");
    reader_read_a: assert property (
        $fell(O_READER_DATA_READY) |-> $fell(O_READER_LOCK))
        else $error("ready cleared without lock release");
    off_pulse_a: assert property (
        $fell(O_READER_DATA_READY) && I_EVENT_OFF_SELECT == 2'h3
        |-> ##[0:1] !O_FIELD_DETECT_PIN_OE) else $error("no read pulse");
    not_owner_a: assert property (
        !O_I2C_LOCK && !O_READER_LOCK && (I_I2C_WR_DONE || I_I2C_RD_DONE)
        |=> $stable(O_HOST_READY) && $stable(O_READER_DATA_READY))
        else $error("flags changed by non-owner");
endmodule
bind sram_passthrough_handshake pthru_monitor pthru_monitor_i (
    .I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN),
    .I_I2C_ADDR_MATCH(I_I2C_ADDR_MATCH), .I_I2C_WR_DONE(I_I2C_WR_DONE),
    .I_I2C_RD_DONE(I_I2C_RD_DONE), .I_I2C_PAGE(I_I2C_PAGE),
    .I_EVENT_ON_SELECT(I_EVENT_ON_SELECT),
    .I_EVENT_OFF_SELECT(I_EVENT_OFF_SELECT),
    .O_HOST_READY(O_HOST_READY), .O_READER_LOCK(O_READER_LOCK),
    .O_READER_DATA_READY(O_READER_DATA_READY), .O_I2C_LOCK(O_I2C_LOCK),
    .O_FIELD_DETECT_PIN_OUT(O_FIELD_DETECT_PIN_OUT),
    .O_FIELD_DETECT_PIN_OE(O_FIELD_DETECT_PIN_OE)
);

// [test/reader_model.sv]
/* contactless reader model: one command per link clock period.
   assumes the core clock only to start a command off a clean edge. */
`timescale 1ns/1ps
module reader_model (
    input  wire logic       i_clk,
    output logic            o_rf_clk,
    output logic            o_req,
    output logic            o_wr_done,
    output logic            o_rd_done,
    output logic [7:0]      o_first,
    output logic [7:0]      o_last
);
    // quiet link: clock stands still between frames
    initial begin
        o_rf_clk = 1'b0;
        o_req = 1'b0;
        o_wr_done = 1'b0;
        o_rd_done = 1'b0;
        o_first = 8'h00;
        o_last = 8'h00;
    end
    // levels set 150 ns before the rise and held 160 ns after it,
    // so the link edge lands off the core clock's phase
    task automatic cmd(input logic w, r, input logic [7:0] f, l);
        @(posedge i_clk);
        o_req <= 1'b1;
        o_wr_done <= w;
        o_rd_done <= r;
        o_first <= f;
        o_last <= l;
        #150;
        o_rf_clk = 1'b1;
        #160;
        o_rf_clk = 1'b0;
        o_wr_done = 1'b0;
        o_rd_done = 1'b0;
        o_first = ~f; // released pages show no stale value
        o_last = ~l;
    endtask
endmodule

// [test/testbench.sv]
/* self-checking bench of the pass-through handshake block.
   assumes the reader model and the bound port checker. */
`timescale 1ns/1ps
module testbench;
    logic       clk, rst_n, addr_match, i2c_wr, i2c_rd; // core inputs
    logic [7:0] i2c_page, rf_first, rf_last;
    logic [1:0] on_sel, off_sel;             // event select bits
    logic       rf_clk, rf_req, rf_wr, rf_rd; // reader side
    logic       host_ready, rdr_ready, rdr_lock, i2c_lock, fd_out, fd_oe;
    logic [3:0] st;                          // status flags together
    int         num_errors, check_count, lows, lows_base;
    assign st = {host_ready, rdr_ready, rdr_lock, i2c_lock};
    sram_passthrough_handshake sram_passthrough_handshake_i (
        .I_CORE_CLK(clk), .I_RESETN(rst_n), .I_RF_CLK(rf_clk),
        .I_RF_REQ(rf_req), .I_RF_WR_DONE(rf_wr), .I_RF_RD_DONE(rf_rd),
        .I_RF_FIRST_PAGE(rf_first), .I_RF_LAST_PAGE(rf_last),
        .I_I2C_ADDR_MATCH(addr_match), .I_I2C_WR_DONE(i2c_wr),
        .I_I2C_RD_DONE(i2c_rd), .I_I2C_PAGE(i2c_page),
        .I_EVENT_ON_SELECT(on_sel), .I_EVENT_OFF_SELECT(off_sel),
        .O_HOST_READY(host_ready), .O_READER_DATA_READY(rdr_ready),
        .O_READER_LOCK(rdr_lock), .O_I2C_LOCK(i2c_lock),
        .O_FIELD_DETECT_PIN_OUT(fd_out), .O_FIELD_DETECT_PIN_OE(fd_oe));
    reader_model reader_model_i (.i_clk(clk), .o_rf_clk(rf_clk),
        .o_req(rf_req), .o_wr_done(rf_wr), .o_rd_done(rf_rd),
        .o_first(rf_first), .o_last(rf_last));
    // counts low samples of the pin in the background
    always @(negedge clk) lows <= lows + int'(fd_oe === 1'b0);
    task automatic chk(input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // polls the flags for up to 60 cycles, then compares
    task automatic wait_st(input logic [3:0] exp);
        int n;
        n = 0;
        while (st !== exp && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk({4'h0, st}, {4'h0, exp});
        // only a bound used up without a match ends the run early
        if (st !== exp) final_report();
    endtask
    // one-cycle i2c result pulse, then the expected flags
    task automatic ip(input logic a, w, r, input logic [7:0] p,
                      input logic [3:0] exp);
        @(posedge clk);
        addr_match <= a;
        i2c_wr <= w;
        i2c_rd <= r;
        i2c_page <= p;
        @(posedge clk);
        addr_match <= 1'b0;
        i2c_wr <= 1'b0;
        i2c_rd <= 1'b0;
        i2c_page <= ~p;
        @(negedge clk);
        wait_st(exp);
    endtask
    task automatic rf(input logic w, r, input logic [7:0] f, l,
                      input logic [3:0] exp);
        reader_model_i.cmd(w, r, f, l);
        wait_st(exp);
    endtask
    // low time seen since the last check; 40 cycles lets a pulse end.
    // the counter itself is never cleared here, so it keeps one driver
    task automatic fd_check(input int exp);
        repeat (40) @(negedge clk);
        chk(8'(lows - lows_base), 8'(exp));
        lows_base = lows;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst_n, addr_match, i2c_wr, i2c_rd, i2c_page} = 12'h000;
        on_sel = pthru_pkg::SEL_PTHRU;
        off_sel = pthru_pkg::SEL_PTHRU;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(8'({st, fd_oe, fd_out}), 8'h02);
        @(posedge clk);
        rst_n <= 1'b1;
        rf(1'b0, 1'b0, 8'h00, 8'h00, 4'b0010);
        ip(1'b1, 1'b0, 1'b0, 8'h00, 4'b0010);
        ip(1'b0, 1'b1, 1'b0, 8'hFB, 4'b0010);
        rf(1'b1, 1'b0, 8'hF0, 8'hF0, 4'b0010);
        rf(1'b1, 1'b0, 8'hFF, 8'hFF, 4'b1000);
        fd_check(25);
        rf(1'b0, 1'b0, 8'h00, 8'h00, 4'b1000);
        ip(1'b1, 1'b0, 1'b0, 8'h00, 4'b1001);
        rf(1'b1, 1'b0, 8'hFF, 8'hFF, 4'b1001);
        ip(1'b0, 1'b0, 1'b1, 8'hF0, 4'b1001);
        ip(1'b0, 1'b0, 1'b1, 8'hFF, 4'b0000);
        ip(1'b0, 1'b1, 1'b0, 8'hFB, 4'b0000);
        // second pass with the read pulse turned off
        for (int k = 0; k < 2; k++) begin
            off_sel <= (k == 0) ? pthru_pkg::SEL_PTHRU : 2'h0;
            ip(1'b1, 1'b0, 1'b0, 8'h00, 4'b0001);
            ip(1'b0, 1'b1, 1'b0, 8'hF0, 4'b0001);
            ip(1'b0, 1'b1, 1'b0, 8'hFB, 4'b0110);
            rf(1'b0, 1'b1, 8'hF0, 8'hFE, 4'b0110);
            rf(1'b0, 1'b1, 8'hF8, 8'hFF, 4'b0000);
            fd_check((k == 0) ? 25 : 0);
        end
        final_report();
    end
endmodule
